/* File: hw_cursor_defines.svh */
/*
 * Constants of the hardware cursor register set: register indices,
 * field positions, reset values and pattern storage geometry.
 * Assumes it is included by bare name, once per compilation unit.
 */
`ifndef HW_CURSOR_DEFINES_SVH
`define HW_CURSOR_DEFINES_SVH

// ****************************************************************
// Register indices on the indexed data port
// ****************************************************************
`define IDX_LOCK_KEY   8'h39
`define IDX_MODE       8'h45
`define IDX_ORG_X_HI   8'h46
`define IDX_ORG_X_LO   8'h47
`define IDX_ORG_Y_HI   8'h48
`define IDX_ORG_Y_LO   8'h49
`define IDX_FG_STACK   8'h4a
`define IDX_BG_STACK   8'h4b
`define IDX_START_HI   8'h4c
`define IDX_START_LO   8'h4d
`define IDX_PAT_COL    8'h4e
`define IDX_PAT_ROW    8'h4f

// ****************************************************************
// Field positions and keys
// ****************************************************************
`define MODE_ENABLE_BIT 0
`define MODE_RIGHT_BIT  4
`define LOCK_KEY_MSB    7
`define LOCK_KEY_LSB    5
`define LOCK_KEY_VALUE  3'h5
`define STACK_LAST      2'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_MODE      8'h00
`define RST_LOCK_KEY  8'h00
`define RST_ORG_X     11'h000

// ****************************************************************
// Pattern storage geometry, in bytes
// ****************************************************************
`define ROW_BYTES_LOG2   4
`define LINE_1K_LOG2     10
`define RIGHT_OFS_4BPP   12'h300
`define RIGHT_OFS_8BPP   12'h600

`endif

/* File: hw_cursor_pkg.sv */
/*
 * Types of the hardware cursor register set.
 * Assumes hw_cursor_defines.svh is compiled alongside.
 */
package hw_cursor_pkg;

   typedef logic [7:0] byte_t;
   typedef logic [10:0] coord_t;
   typedef logic [1:0] stack_ptr_t;

   // Whole register state of the cursor register set
   typedef struct packed {
      byte_t lock_key;
      logic mode_enable;
      logic mode_right;
      logic [2:0] stage_x_hi;
      byte_t stage_x_lo;
      logic [2:0] stage_y_hi;
      byte_t stage_y_lo;
      coord_t cur_x;
      coord_t cur_y;
      logic [2:0][7:0] fg;
      logic [2:0][7:0] bg;
      stack_ptr_t stack_ptr;
      logic [3:0] start_hi;
      byte_t start_lo;
      logic [5:0] pat_col;
      logic [5:0] pat_row;
      byte_t rdata;
   } cursor_state_s;

endpackage

/* File: cursor_pattern_addr.sv */
/*
 * Cursor pattern line address generator.
 * Assumes the display side asks for one pattern row per request and
 * that the storage start counts 1 KiB lines of display memory.
 */
`timescale 1ns/1ns
`include "hw_cursor_defines.svh"

module cursor_pattern_addr (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [11:0] start_i,
   input wire logic right_i,
   input wire logic bits8_i,
   input wire logic [5:0] row_i,
   output logic [21:0] addr_o
);
   import hw_cursor_pkg::*;

   logic [21:0] next_addr;
   logic [21:0] base;
   logic [11:0] in_line;

   // ****************************************************************
   // Byte address of the requested pattern row
   // ****************************************************************
   always_comb begin
      base = {start_i, 10'h000};
      in_line = 12'h000;
      if (right_i && !bits8_i) begin
         // Last 256 bytes of each 1 KiB line, 16 rows per line
         base = {start_i + {8'h00, 2'b00, row_i[5:4]}, 10'h000};
         in_line = `RIGHT_OFS_4BPP | {4'h0, row_i[3:0], 4'h0};
      end else if (right_i) begin
         // Last 512 bytes of each 2 KiB line, 32 rows per line
         base = {start_i + {8'h00, 2'b00, row_i[5], 1'b0}, 10'h000};
         in_line = `RIGHT_OFS_8BPP | {3'h0, row_i[4:0], 4'h0};
      end else begin
         in_line = {2'b00, row_i, 4'h0};
      end
      next_addr = base + {10'h000, in_line};
   end

   // Registered address
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_o <= 22'h000000;
      end else begin
         addr_o <= next_addr;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_right_4bpp;
      @(posedge core_clk_i) disable iff (rst_i)
      (right_i && !bits8_i) |=> (addr_o[9:8] == 2'b11);
   endproperty
   a_right_4bpp: assert property (p_right_4bpp) else $error("4bpp right area wrong");

   // Offset from the start line must fall in the last 512 bytes of a 2 KiB line
   property p_right_8bpp;
      @(posedge core_clk_i) disable iff (rst_i)
      (right_i && bits8_i) |=>
         (((addr_o - {$past(start_i), 10'h000}) & 22'h000600) == 22'h000600);
   endproperty
   a_right_8bpp: assert property (p_right_8bpp) else $error("8bpp right area wrong");

endmodule

/* File: hw_cursor_control_regs.sv */
/*
 * Hardware cursor control register set behind the indexed data port.
 * Assumes one host cycle per strobe on core_clk_i, index and data stable
 * with the strobe, and enhanced_mode_i driven from the same clock.
 */
// Contract
// - Cursor shown only when enabled in Enhanced mode
// - Right storage 4bpp: last 256 bytes per 1K
// - Right storage 8bpp: last 512 bytes per 2K
// - Eleven-bit left X split high/low
// - Eleven-bit top Y split high/low
// - High Y write commits X and Y together
// - Three foreground bytes written via stack pointer
// - Three background bytes written, pointer advances
// - Shared pointer: mode read clears, writes increment
// - Twelve-bit pattern storage start address
// - Six-bit pattern start column offset
// - Six-bit pattern start row offset
// - Registers locked until key top bits 101
`timescale 1ns/1ns
`include "hw_cursor_defines.svh"

module hw_cursor_control_regs (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire hw_cursor_pkg::byte_t reg_index_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire hw_cursor_pkg::byte_t reg_wdata_i,
   output hw_cursor_pkg::byte_t reg_rdata_o,
   input wire logic enhanced_mode_i,
   input wire logic bits8_i,
   input wire logic [5:0] pattern_row_i,
   output logic cursor_visible_o,
   output logic right_storage_select_o,
   output hw_cursor_pkg::coord_t cursor_x_o,
   output hw_cursor_pkg::coord_t cursor_y_o,
   output logic [23:0] fg_color_o,
   output logic [23:0] bg_color_o,
   output logic [11:0] storage_start_o,
   output logic [5:0] pattern_start_column_o,
   output logic [5:0] pattern_start_row_o,
   output logic [21:0] pattern_addr_o
);
   import hw_cursor_pkg::*;

   cursor_state_s state;
   cursor_state_s next_state;
   logic unlocked;
   logic wr_ok;
   logic rd_ok;

   // Reset image of the mode register; only two of its bits are kept
   localparam byte_t mode_reset = `RST_MODE;

   // ****************************************************************
   // Index decoding
   // ****************************************************************

   // True for any index of the set from mode to pattern row; the key register is left out
   function automatic logic is_cursor_index(input byte_t idx);
      is_cursor_index = (idx >= `IDX_MODE) && (idx <= `IDX_PAT_ROW);
   endfunction

   // Next stack position, wrapping after the third byte
   function automatic stack_ptr_t ptr_advance(input stack_ptr_t p);
      ptr_advance = (p == `STACK_LAST) ? 2'h0 : p + 2'h1;
   endfunction

   // Key gate; the key register itself stays reachable
   assign unlocked = (state.lock_key[`LOCK_KEY_MSB:`LOCK_KEY_LSB] == `LOCK_KEY_VALUE);
   assign wr_ok = reg_wr_i && unlocked && is_cursor_index(reg_index_i);
   assign rd_ok = reg_rd_i && unlocked && is_cursor_index(reg_index_i);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_state = state;
      // Key register writes
      if (reg_wr_i && (reg_index_i == `IDX_LOCK_KEY)) begin
         next_state.lock_key = reg_wdata_i;
      end
      // Cursor register writes, reserved bits dropped
      if (wr_ok) begin
         case (reg_index_i)
            `IDX_MODE: begin
               next_state.mode_enable = reg_wdata_i[`MODE_ENABLE_BIT];
               next_state.mode_right = reg_wdata_i[`MODE_RIGHT_BIT];
            end
            `IDX_ORG_X_HI: begin
               next_state.stage_x_hi = reg_wdata_i[2:0];
            end
            `IDX_ORG_X_LO: begin
               next_state.stage_x_lo = reg_wdata_i;
            end
            `IDX_ORG_Y_HI: begin
               // Commit both staged coordinates at once
               next_state.stage_y_hi = reg_wdata_i[2:0];
               next_state.cur_x = {state.stage_x_hi, state.stage_x_lo};
               next_state.cur_y = {reg_wdata_i[2:0], state.stage_y_lo};
            end
            `IDX_ORG_Y_LO: begin
               next_state.stage_y_lo = reg_wdata_i;
            end
            `IDX_FG_STACK: begin
               next_state.fg[state.stack_ptr] = reg_wdata_i;
               next_state.stack_ptr = ptr_advance(state.stack_ptr);
            end
            `IDX_BG_STACK: begin
               next_state.bg[state.stack_ptr] = reg_wdata_i;
               next_state.stack_ptr = ptr_advance(state.stack_ptr);
            end
            `IDX_START_HI: begin
               next_state.start_hi = reg_wdata_i[3:0];
            end
            `IDX_START_LO: begin
               next_state.start_lo = reg_wdata_i;
            end
            `IDX_PAT_COL: begin
               next_state.pat_col = reg_wdata_i[5:0];
            end
            `IDX_PAT_ROW: begin
               next_state.pat_row = reg_wdata_i[5:0];
            end
            default: begin
               next_state.lock_key = next_state.lock_key;
            end
         endcase
      end
      // Read data; a locked or foreign index reads as zero
      next_state.rdata = 8'h00;
      if (reg_rd_i && (reg_index_i == `IDX_LOCK_KEY)) begin
         next_state.rdata = state.lock_key;
      end
      if (rd_ok) begin
         case (reg_index_i)
            `IDX_MODE: begin
               next_state.rdata = {3'h0, state.mode_right, 3'h0, state.mode_enable};
               next_state.stack_ptr = 2'h0;
            end
            `IDX_ORG_X_HI: begin
               next_state.rdata = {5'h00, state.stage_x_hi};
            end
            `IDX_ORG_X_LO: begin
               next_state.rdata = state.stage_x_lo;
            end
            `IDX_ORG_Y_HI: begin
               next_state.rdata = {5'h00, state.stage_y_hi};
            end
            `IDX_ORG_Y_LO: begin
               next_state.rdata = state.stage_y_lo;
            end
            `IDX_FG_STACK: begin
               next_state.rdata = state.fg[state.stack_ptr];
            end
            `IDX_BG_STACK: begin
               next_state.rdata = state.bg[state.stack_ptr];
            end
            `IDX_START_HI: begin
               next_state.rdata = {4'h0, state.start_hi};
            end
            `IDX_START_LO: begin
               next_state.rdata = state.start_lo;
            end
            `IDX_PAT_COL: begin
               next_state.rdata = {2'b00, state.pat_col};
            end
            `IDX_PAT_ROW: begin
               next_state.rdata = {2'b00, state.pat_row};
            end
            default: begin
               next_state.rdata = 8'h00;
            end
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= '0;
         state.lock_key <= `RST_LOCK_KEY;
         state.mode_enable <= mode_reset[`MODE_ENABLE_BIT];
         state.mode_right <= mode_reset[`MODE_RIGHT_BIT];
         state.cur_x <= `RST_ORG_X;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Cursor shown only in Enhanced mode with the enable set
   assign cursor_visible_o = state.mode_enable && enhanced_mode_i;
   assign right_storage_select_o = state.mode_right;
   assign cursor_x_o = state.cur_x;
   assign cursor_y_o = state.cur_y;
   assign storage_start_o = {state.start_hi, state.start_lo};
   assign pattern_start_column_o = state.pat_col;
   assign pattern_start_row_o = state.pat_row;
   assign reg_rdata_o = state.rdata;

   // Colour stacks flattened, byte 0 in the low lane
   generate
      for (genvar i = 0; i < 3; i++) begin : g_color
         assign fg_color_o[8*i +: 8] = state.fg[i];
         assign bg_color_o[8*i +: 8] = state.bg[i];
      end
   endgenerate

   // Pattern row addressing, right storage honoured
   cursor_pattern_addr cursor_pattern_addr_inst (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .start_i(storage_start_o),
      .right_i(state.mode_right),
      .bits8_i(bits8_i),
      .row_i(pattern_row_i),
      .addr_o(pattern_addr_o)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   property p_enable_off;
      (wr_ok && reg_index_i == `IDX_MODE && !reg_wdata_i[0]) |=> !cursor_visible_o;
   endproperty
   a_enable_off: assert property (p_enable_off) else $error("cursor shown while off");

   property p_commit;
      (wr_ok && reg_index_i == `IDX_ORG_Y_HI) |=>
         (cursor_y_o == {$past(reg_wdata_i[2:0]), $past(state.stage_y_lo)}) &&
         (cursor_x_o == {$past(state.stage_x_hi), $past(state.stage_x_lo)});
   endproperty
   a_commit: assert property (p_commit) else $error("origin not committed");

   property p_no_move;
      (reg_wr_i && reg_index_i != `IDX_ORG_Y_HI) |=>
         $stable(cursor_x_o) && $stable(cursor_y_o);
   endproperty
   a_no_move: assert property (p_no_move) else $error("cursor moved early");

   property p_ptr_clear;
      (rd_ok && reg_index_i == `IDX_MODE) |=> (state.stack_ptr == 2'h0);
   endproperty
   a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared");

   property p_ptr_inc;
      (wr_ok && reg_index_i[7:1] == 7'h25 && state.stack_ptr != 2'h2) |=>
         (state.stack_ptr == $past(state.stack_ptr) + 2'h1);
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");

   property p_ptr_wrap;
      (wr_ok && reg_index_i == `IDX_BG_STACK && state.stack_ptr == 2'h2) |=>
         (state.stack_ptr == 2'h0);
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer not wrapped");

   property p_fg_first;
      (wr_ok && reg_index_i == `IDX_FG_STACK && state.stack_ptr == 2'h0) |=>
         (fg_color_o[7:0] == $past(reg_wdata_i));
   endproperty
   a_fg_first: assert property (p_fg_first) else $error("fg byte 0 lost");

   property p_bg_last;
      (wr_ok && reg_index_i == `IDX_BG_STACK && state.stack_ptr == 2'h2) |=>
         (bg_color_o[23:16] == $past(reg_wdata_i));
   endproperty
   a_bg_last: assert property (p_bg_last) else $error("bg byte 2 lost");

   property p_locked;
      (reg_rd_i && !unlocked && is_cursor_index(reg_index_i)) |=>
         (reg_rdata_o == 8'h00) && $stable(storage_start_o);
   endproperty
   a_locked: assert property (p_locked) else $error("locked access leaked");

   property p_start;
      (wr_ok && reg_index_i == `IDX_START_LO) |=> (storage_start_o[7:0] == $past(reg_wdata_i));
   endproperty
   a_start: assert property (p_start) else $error("start low not stored");

   // Each offset write lands on its own, whatever the spacing of writes
   property p_offsets;
      (wr_ok && reg_index_i == `IDX_PAT_COL) |=>
         (pattern_start_column_o == $past(reg_wdata_i[5:0]));
   endproperty
   a_offsets: assert property (p_offsets) else $error("pattern column wrong");

   property p_row_store;
      (wr_ok && reg_index_i == `IDX_PAT_ROW) |=>
         (pattern_start_row_o == $past(reg_wdata_i[5:0]));
   endproperty
   a_row_store: assert property (p_row_store) else $error("pattern row wrong");

   property p_start_hi;
      (wr_ok && reg_index_i == `IDX_START_HI) |=>
         (storage_start_o[11:8] == $past(reg_wdata_i[3:0]));
   endproperty
   a_start_hi: assert property (p_start_hi) else $error("start high not stored");

   // Enable follows the written bit, gated by Enhanced mode
   property p_visible_on;
      (wr_ok && reg_index_i == `IDX_MODE && reg_wdata_i[`MODE_ENABLE_BIT]) |=>
         (cursor_visible_o == enhanced_mode_i);
   endproperty
   a_visible_on: assert property (p_visible_on) else $error("cursor enable ignored");

   property p_mode_read;
      (rd_ok && reg_index_i == `IDX_MODE) |=>
         (reg_rdata_o == {3'h0, $past(state.mode_right), 3'h0, $past(state.mode_enable)});
   endproperty
   a_mode_read: assert property (p_mode_read) else $error("mode read back wrong");

   // A locked write must leave the enable, the stack pointer and the foreground colour untouched
   property p_locked_write;
      (reg_wr_i && !unlocked && is_cursor_index(reg_index_i)) |=>
         $stable(state.mode_enable) && $stable(state.stack_ptr) && $stable(fg_color_o);
   endproperty
   a_locked_write: assert property (p_locked_write) else $error("locked write landed");

   // Reading a colour stack shows the entry but keeps the pointer
   property p_ptr_read_hold;
      (rd_ok && reg_index_i[7:1] == 7'h25) |=> $stable(state.stack_ptr);
   endproperty
   a_ptr_read_hold: assert property (p_ptr_read_hold) else $error("stack read moved pointer");

   c_unlock: cover property (reg_wr_i && reg_index_i == `IDX_LOCK_KEY ##1 unlocked);
   c_commit: cover property (wr_ok && reg_index_i == `IDX_ORG_Y_HI);
   c_wrap: cover property (wr_ok && reg_index_i == `IDX_FG_STACK && state.stack_ptr == 2'h2);
   c_visible: cover property (cursor_visible_o && right_storage_select_o);
   // Key changed away from the unlock pattern
   c_relock: cover property (unlocked ##1 !unlocked);

endmodule

/* File: hw_cursor_control_regs_tb_top.sv */
/*
 * Self-checking testbench of the hardware cursor register set.
 * Assumes hw_cursor_pkg and hw_cursor_defines.svh are compiled first.
 */
`timescale 1ns/1ns
`include "hw_cursor_defines.svh"

module hw_cursor_control_regs_tb_top;
   import hw_cursor_pkg::*;

   // ****************************************************************
   // Signals and the design under test
   // ****************************************************************
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   byte_t reg_index_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   byte_t reg_wdata_i = 8'h00;
   byte_t reg_rdata_o;
   logic enhanced_mode_i = 1'b0;
   logic bits8_i = 1'b0;
   logic [5:0] pattern_row_i = 6'h00;
   logic cursor_visible_o;
   logic right_storage_select_o;
   coord_t cursor_x_o;
   coord_t cursor_y_o;
   logic [23:0] fg_color_o;
   logic [23:0] bg_color_o;
   logic [11:0] storage_start_o;
   logic [5:0] pattern_start_column_o;
   logic [5:0] pattern_start_row_o;
   logic [21:0] pattern_addr_o;
   int error_cnt = 0;
   int compares = 0;

   hw_cursor_control_regs hw_cursor_control_regs_inst (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_index_i(reg_index_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .enhanced_mode_i(enhanced_mode_i),
      .bits8_i(bits8_i), .pattern_row_i(pattern_row_i),
      .cursor_visible_o(cursor_visible_o),
      .right_storage_select_o(right_storage_select_o),
      .cursor_x_o(cursor_x_o), .cursor_y_o(cursor_y_o),
      .fg_color_o(fg_color_o), .bg_color_o(bg_color_o),
      .storage_start_o(storage_start_o),
      .pattern_start_column_o(pattern_start_column_o),
      .pattern_start_row_o(pattern_start_row_o),
      .pattern_addr_o(pattern_addr_o)
   );

   // Clock of 40 ns period
   initial begin
      forever #20 core_clk_i = ~core_clk_i;
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   // Compare one observed value with its expectation
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One-cycle write strobe, released at the following falling edge
   task automatic wr(input byte_t idx, input byte_t data);
      @(negedge core_clk_i);
      reg_index_i = idx;
      reg_wdata_i = data;
      reg_wr_i = 1'b1;
      @(negedge core_clk_i);
      reg_wr_i = 1'b0;
   endtask

   // One-cycle read strobe; read data stands in the following cycle
   task automatic rd(input byte_t idx, input byte_t exp, input string what);
      @(negedge core_clk_i);
      reg_index_i = idx;
      reg_rd_i = 1'b1;
      @(negedge core_clk_i);
      reg_rd_i = 1'b0;
      chk(reg_rdata_o, exp, what);
   endtask

   // Verdict and end of run
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   // Locked after reset: writes ignored, reads give zero
   task automatic sc_locked();
      chk(cursor_x_o, 24'h0, "x after reset");
      chk(cursor_visible_o, 24'h0, "visible after reset");
      enhanced_mode_i = 1'b1;
      wr(`IDX_MODE, 8'h01);
      rd(`IDX_MODE, 8'h00, "locked mode read");
      chk(cursor_visible_o, 24'h0, "locked enable");
      wr(`IDX_LOCK_KEY, 8'ha0);
   endtask

   // Enable bit gated by Enhanced mode, right storage bit
   task automatic sc_enable();
      wr(`IDX_MODE, 8'h11);
      chk(cursor_visible_o, 24'h1, "enabled enhanced");
      chk(right_storage_select_o, 24'h1, "right select");
      @(negedge core_clk_i);
      enhanced_mode_i = 1'b0;
      @(negedge core_clk_i);
      chk(cursor_visible_o, 24'h0, "not enhanced");
      enhanced_mode_i = 1'b1;
      wr(`IDX_MODE, 8'h10);
      chk(cursor_visible_o, 24'h0, "disabled");
      rd(`IDX_MODE, 8'h10, "mode read");
   endtask

   // Staged origin moves only on the high Y write
   task automatic sc_origin();
      wr(`IDX_ORG_X_LO, 8'h10);
      wr(`IDX_ORG_X_HI, 8'h01);
      wr(`IDX_ORG_Y_LO, 8'h20);
      chk(cursor_x_o, 24'h0, "x before commit");
      chk(cursor_y_o, 24'h0, "y before commit");
      wr(`IDX_ORG_Y_HI, 8'h02);
      chk(cursor_x_o, 24'h110, "x commit");
      chk(cursor_y_o, 24'h220, "y commit");
      wr(`IDX_ORG_X_HI, 8'h07);
      wr(`IDX_ORG_X_LO, 8'hff);
      wr(`IDX_ORG_Y_LO, 8'hff);
      chk(cursor_x_o, 24'h110, "x held");
      wr(`IDX_ORG_Y_HI, 8'h07);
      chk(cursor_x_o, 24'h7ff, "x max");
      chk(cursor_y_o, 24'h7ff, "y max");
   endtask

   // Shared colour pointer: clear on mode read, advance, wrap
   task automatic sc_colour();
      rd(`IDX_MODE, 8'h10, "mode read clears pointer");
      wr(`IDX_FG_STACK, 8'h11);
      wr(`IDX_FG_STACK, 8'h22);
      wr(`IDX_FG_STACK, 8'h33);
      chk(fg_color_o, 24'h332211, "fg three bytes");
      wr(`IDX_FG_STACK, 8'h44);
      chk(fg_color_o, 24'h332244, "fg wrap");
      rd(`IDX_MODE, 8'h10, "mode read");
      wr(`IDX_FG_STACK, 8'haa);
      wr(`IDX_BG_STACK, 8'hbb);
      wr(`IDX_BG_STACK, 8'hcc);
      chk(bg_color_o[23:8], 24'hccbb, "bg shares pointer");
      chk(fg_color_o, 24'h3322aa, "fg entry 0");
      rd(`IDX_MODE, 8'h10, "mode read");
      rd(`IDX_FG_STACK, 8'haa, "fg read at entry 0");
   endtask

   // Start address, pattern offsets and right storage addressing
   task automatic sc_pattern();
      wr(`IDX_START_HI, 8'h0a);
      wr(`IDX_START_LO, 8'h5f);
      chk(storage_start_o, 24'ha5f, "start 12 bits");
      wr(`IDX_PAT_COL, 8'h3f);
      wr(`IDX_PAT_ROW, 8'h2a);
      chk(pattern_start_column_o, 24'h3f, "column");
      chk(pattern_start_row_o, 24'h2a, "row");
      rd(`IDX_PAT_COL, 8'h3f, "column read");
      // Start low bits 11 before right storage is used
      wr(`IDX_START_HI, 8'h00);
      wr(`IDX_START_LO, 8'h03);
      pattern_row_i = 6'd17;
      bits8_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      chk(pattern_addr_o, (3 + 1) * 1024 + 12'h300 + 16, "right 4bpp");
      pattern_row_i = 6'd33;
      bits8_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      chk(pattern_addr_o, (3 + 2) * 1024 + 12'h600 + 16, "right 8bpp");
      wr(`IDX_MODE, 8'h01);
      pattern_row_i = 6'd17;
      repeat (2) @(negedge core_clk_i);
      chk(pattern_addr_o, 3 * 1024 + 17 * 16, "normal");
   endtask

   // Changing a key bit locks the set again
   task automatic sc_relock();
      wr(`IDX_LOCK_KEY, 8'h80);
      rd(`IDX_MODE, 8'h00, "relocked read");
      wr(`IDX_MODE, 8'h00);
      wr(`IDX_LOCK_KEY, 8'hbf);
      rd(`IDX_MODE, 8'h01, "write while locked ignored");
   endtask

   // Mid-run reset clears the set and locks it again
   task automatic sc_reset();
      @(negedge core_clk_i);
      rst_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      rst_i = 1'b0;
      chk(cursor_x_o, 24'h0, "x after second reset");
      chk(storage_start_o, 24'h0, "start after second reset");
      rd(`IDX_LOCK_KEY, 8'h00, "key after second reset");
      wr(`IDX_MODE, 8'h01);
      chk(cursor_visible_o, 24'h0, "locked after second reset");
      wr(`IDX_LOCK_KEY, 8'ha0);
      rd(`IDX_MODE, 8'h00, "mode write refused after reset");
   endtask

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   // Reset for 8 cycles, then the scenarios in order
   initial begin
      repeat (8) @(negedge core_clk_i);
      rst_i = 1'b0;
      sc_locked();
      sc_enable();
      sc_origin();
      sc_colour();
      sc_pattern();
      sc_relock();
      sc_reset();
      report_and_stop();
   end

   // Bound on the whole run
   initial begin
      #400000;
      error_cnt++;
      report_and_stop();
   end

endmodule
